// ### hdl/tfs_out_ff.sv
// timer flip-flop with software command and hardware toggle triggers
`timescale 1ns/1ps
module tfs_out_ff (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	// software command
	input  wire logic                  cmd_valid,
	input  wire tfs_pkg::tfs_ff_cmd_e  cmd,
	// hardware triggers
	input  wire tfs_pkg::tfs_trig_en_s trig_en,
	input  wire tfs_pkg::tfs_trig_ev_s trig_ev,
	// output
	output logic                       timer_flip_flop
);

	logic timer_flip_flop_ff;
	logic hw_toggle;

	// any enabled event inverts once
	assign hw_toggle = (trig_en.capture1_toggle_enable & trig_ev.capture1)
		| (trig_en.capture0_toggle_enable & trig_ev.capture0)
		| (trig_en.match1_toggle_enable & trig_ev.match1)
		| (trig_en.match0_toggle_enable & trig_ev.match0);

	// software invert, set or clear command takes priority over hardware toggles
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_flip_flop_ff <= 1'b0;
		end else if (cmd_valid && cmd != tfs_pkg::FF_KEEP) begin
			unique case (cmd)
				tfs_pkg::FF_INVERT: timer_flip_flop_ff <= ~timer_flip_flop_ff;
				tfs_pkg::FF_SET:    timer_flip_flop_ff <= 1'b1;
				tfs_pkg::FF_CLEAR:  timer_flip_flop_ff <= 1'b0;
				tfs_pkg::FF_KEEP:   timer_flip_flop_ff <= timer_flip_flop_ff;
			endcase
		end else if (hw_toggle) begin
			timer_flip_flop_ff <= ~timer_flip_flop_ff;
		end
	end

	assign timer_flip_flop = timer_flip_flop_ff;

endmodule

// ### hdl/tfs_pkg.sv
// constants and types shared by the timer flip-flop and status block
package tfs_pkg;

	// register byte offsets on the plain register port
	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_FFCR   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IMASK  = 8'h0C;
	localparam logic [7:0] OFS_CMP0   = 8'h10;
	localparam logic [7:0] OFS_CMP1   = 8'h14;
	localparam logic [7:0] OFS_RUN    = 8'h18;

	// mode register fields
	localparam int MODE_CLK_LSB   = 0;
	localparam int MODE_CLE_BIT   = 2;
	localparam int MODE_SWCAP_BIT = 5;
	localparam int MODE_W6_BIT    = 6;
	localparam logic [1:0] MODE_CLK_RST = 2'h0;

	// flip-flop control register fields
	localparam int FFCR_CMD_LSB = 0;
	localparam int FFCR_E0T_BIT = 2;
	localparam int FFCR_E1T_BIT = 3;
	localparam int FFCR_C0T_BIT = 4;
	localparam int FFCR_C1T_BIT = 5;
	localparam logic [7:0] FFCR_FIXED_ONES = 8'hC3;

	// status and mask bit positions
	localparam int ST_MATCH0_BIT = 0;
	localparam int ST_MATCH1_BIT = 1;
	localparam int ST_OVF_BIT    = 2;
	localparam int ST_W          = 3;

	// run control field
	localparam int RUN_BIT = 0;

	// prescaler tap masks
	localparam logic [3:0] TAP4_MASK  = 4'h3;
	localparam logic [3:0] TAP16_MASK = 4'hF;

	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

	// count clock source encodings
	typedef enum logic [1:0] {
		CLK_SERIAL_PIN = 2'h0,
		CLK_TAP_1      = 2'h1,
		CLK_TAP_4      = 2'h2,
		CLK_TAP_16     = 2'h3
	} tfs_clk_sel_e;

	// software command on the timer flip-flop
	typedef enum logic [1:0] {
		FF_INVERT = 2'h0,
		FF_SET    = 2'h1,
		FF_CLEAR  = 2'h2,
		FF_KEEP   = 2'h3
	} tfs_ff_cmd_e;

	// toggle trigger enables
	typedef struct packed {
		logic capture1_toggle_enable;
		logic capture0_toggle_enable;
		logic match1_toggle_enable;
		logic match0_toggle_enable;
	} tfs_trig_en_s;

	// hardware toggle events for the timer flip-flop
	typedef struct packed {
		logic capture1;
		logic capture0;
		logic match1;
		logic match0;
	} tfs_trig_ev_s;

endpackage

// ### hdl/tfs_tick_gen.sv
// count tick generator: prescaler taps and synchronised serial clock pin
`timescale 1ns/1ps
module tfs_tick_gen (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	// control
	input  wire tfs_pkg::tfs_clk_sel_e count_clock_select,
	input  wire logic                  serial_clock_pin_input,
	// tick out
	output logic                       count_tick
);

	logic [3:0] presc_ff;
	logic       pin_s1_ff;
	logic       pin_s2_ff;
	logic       pin_s3_ff;
	logic       prescaler_tap_1;
	logic       prescaler_tap_4;
	logic       prescaler_tap_16;
	logic       pin_rise;

	// free-running prescaler
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			presc_ff <= 4'h0;
		end else begin
			presc_ff <= presc_ff + 4'h1;
		end
	end

	// two-stage synchroniser then an edge history stage
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_s3_ff <= 1'b0;
		end else begin
			pin_s1_ff <= serial_clock_pin_input;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	// tap strobes, one cycle each
	assign prescaler_tap_1  = 1'b1;
	assign prescaler_tap_4  = (presc_ff & tfs_pkg::TAP4_MASK) == tfs_pkg::TAP4_MASK;
	assign prescaler_tap_16 = presc_ff == tfs_pkg::TAP16_MASK;
	assign pin_rise         = pin_s2_ff & ~pin_s3_ff;

	// source select
	always_comb begin
		unique case (count_clock_select)
			tfs_pkg::CLK_SERIAL_PIN: count_tick = pin_rise;
			tfs_pkg::CLK_TAP_1:      count_tick = prescaler_tap_1;
			tfs_pkg::CLK_TAP_4:      count_tick = prescaler_tap_4;
			tfs_pkg::CLK_TAP_16:     count_tick = prescaler_tap_16;
		endcase
	end

endmodule

// ### hdl/tfs_timer.sv
// timer channel top: mode, flip-flop control, status flags and counter
// Function
// - with clear enable set, a compare-1 match resets the up-counter.
// - clock select 00 serial pin, 01/10/11 prescaler taps 1, 4, 16.
// - this channel has no capture pins; capture timing bits are reserved.
// - capture-1 toggle enable inverts the flip-flop on each capture-1 latch.
// - capture-0 toggle enable inverts the flip-flop on each capture-0 latch.
// - match-1 toggle enable inverts the flip-flop on compare-1 match.
// - match-0 toggle enable inverts the flip-flop on compare-0 match.
// - flip-flop field write: 00 invert, 01 set, 10 clear, 11 no change.
// - flip-flop control field always reads back as binary 11.
// - overflow flag, bit 2, set when the up-counter overflows.
// - match-1 flag, bit 1, set on compare-1 match.
// - match-0 flag, bit 0, set on compare-0 match.
// - interrupt only for unmasked events; flags set regardless of mask.
// - reading status returns flags then clears them all; an event in the read cycle still sets its flag.
// - compare registers hold 16 bits; upper bits read zero.
// - mask register has enable bits for overflow, match 1, match 0.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module tfs_timer (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// pins and neighbouring logic
	input  wire logic        serial_clock_pin_input,
	input  wire logic        capture0_event,
	input  wire logic        capture1_event,
	// outputs
	output logic             timer_out,
	output logic             irq
);

	// mode register state
	tfs_pkg::tfs_clk_sel_e    clk_sel_ff;
	logic                     clr_on_match_ff;
	logic                     mode_w6_ff;

	// flip-flop control state
	tfs_pkg::tfs_trig_en_s    trig_en_ff;

	// status, mask, compare, run
	logic [tfs_pkg::ST_W-1:0] status_ff;
	logic [tfs_pkg::ST_W-1:0] imask_ff;
	logic [15:0]              cmp0_ff;
	logic [15:0]              cmp1_ff;
	logic                     run_ff;
	logic [15:0]              count_ff;
	logic [31:0]              rdata_ff;

	// decoded strobes
	logic                     wr_mode;
	logic                     wr_ffcr;
	logic                     wr_imask;
	logic                     wr_cmp0;
	logic                     wr_cmp1;
	logic                     wr_run;
	logic                     rd_status;

	// event pulses
	logic                     count_tick;
	logic                     advance;
	logic                     match0;
	logic                     match1;
	logic                     overflow;
	logic [tfs_pkg::ST_W-1:0] status_set;
	logic [15:0]              nxt_count;
	logic [31:0]              nxt_rdata;
	tfs_pkg::tfs_trig_ev_s    trig_ev;

	// interrupt requests per event
	logic [tfs_pkg::ST_W-1:0] irq_req;

	// read-back words, one per register; unused bits zero, except mode [5] and flip-flop control [1:0] and [7:6], which read one
	logic [31:0]              mode_word;
	logic [31:0]              ffcr_word;
	logic [31:0]              status_word;
	logic [31:0]              imask_word;
	logic [31:0]              cmp0_word;
	logic [31:0]              cmp1_word;
	logic [31:0]              run_word;

	// register map, byte offsets on the register port
	//   0x00 mode
	//     [1:0] count clock select: pin, or prescaler taps 1, 4, 16
	//     [2]   clear the counter on a compare-1 match
	//     [4:3] capture timing, reserved here, reads zero
	//     [5]   reads one, writes ignored
	//     [6]   plain read/write bit
	//   0x04 flip-flop control
	//     [1:0] command on write, reads as ones
	//     [2]   toggle on compare-0 match
	//     [3]   toggle on compare-1 match
	//     [4]   toggle on capture-0 latch
	//     [5]   toggle on capture-1 latch
	//     [7:6] read as ones
	//   0x08 status, cleared by reading: [0] match 0, [1] match 1, [2] overflow
	//   0x0C interrupt mask, same layout as status
	//   0x10 compare register 0, 16 bits
	//   0x14 compare register 1, 16 bits
	//   0x18 run control, [0] counts while set, holds the counter at zero when clear
	//   0x1C and above unmapped
	// unmapped writes are dropped, unmapped reads return zero

	// address decode for writes and the clearing read
	// only the status read has a side effect
	assign wr_mode   = reg_wr && reg_addr == tfs_pkg::OFS_MODE;
	assign wr_ffcr   = reg_wr && reg_addr == tfs_pkg::OFS_FFCR;
	assign wr_imask  = reg_wr && reg_addr == tfs_pkg::OFS_IMASK;
	assign wr_cmp0   = reg_wr && reg_addr == tfs_pkg::OFS_CMP0;
	assign wr_cmp1   = reg_wr && reg_addr == tfs_pkg::OFS_CMP1;
	assign wr_run    = reg_wr && reg_addr == tfs_pkg::OFS_RUN;
	assign rd_status = reg_rd && reg_addr == tfs_pkg::OFS_STATUS;

	// mode register: clock select, clear enable, one plain bit
	// a new clock select takes effect from the next tick on
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_sel_ff      <= tfs_pkg::tfs_clk_sel_e'(tfs_pkg::MODE_CLK_RST);
			clr_on_match_ff <= 1'b0;
			mode_w6_ff      <= 1'b0;
		end else if (wr_mode) begin
			clk_sel_ff      <= tfs_pkg::tfs_clk_sel_e'(
				reg_wdata[tfs_pkg::MODE_CLK_LSB +: 2]);
			clr_on_match_ff <= reg_wdata[tfs_pkg::MODE_CLE_BIT];
			mode_w6_ff      <= reg_wdata[tfs_pkg::MODE_W6_BIT];
		end
	end

	// flip-flop control register: toggle trigger enables
	// the command field is not stored; it acts once, in the write cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			trig_en_ff <= '0;
		end else if (wr_ffcr) begin
			trig_en_ff.capture1_toggle_enable <= reg_wdata[tfs_pkg::FFCR_C1T_BIT];
			trig_en_ff.capture0_toggle_enable <= reg_wdata[tfs_pkg::FFCR_C0T_BIT];
			trig_en_ff.match1_toggle_enable   <= reg_wdata[tfs_pkg::FFCR_E1T_BIT];
			trig_en_ff.match0_toggle_enable   <= reg_wdata[tfs_pkg::FFCR_E0T_BIT];
		end
	end

	// interrupt mask register
	// a one lets that event's flag raise the interrupt
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			imask_ff <= '0;
		end else if (wr_imask) begin
			imask_ff <= reg_wdata[tfs_pkg::ST_W-1:0];
		end
	end

	// compare registers hold 16 bits
	// a new compare value applies from the next tick on
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp0_ff <= 16'h0000;
			cmp1_ff <= 16'h0000;
		end else begin
			if (wr_cmp0) begin
				cmp0_ff <= reg_wdata[15:0];
			end
			if (wr_cmp1) begin
				cmp1_ff <= reg_wdata[15:0];
			end
		end
	end

	// run control
	// writing zero stops the timer and clears the counter
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_ff <= 1'b0;
		end else if (wr_run) begin
			run_ff <= reg_wdata[tfs_pkg::RUN_BIT];
		end
	end

	// count tick source
	// the pin passes a two-stage synchroniser inside, so the tick comes two cycles late
	tfs_tick_gen u_tick (
		.ref_clk                (ref_clk),
		.arst_n                 (arst_n),
		.count_clock_select     (clk_sel_ff),
		.serial_clock_pin_input (serial_clock_pin_input),
		.count_tick             (count_tick)
	);

	// match and overflow events, taken on the tick that leaves the value;
	// a clearing compare-1 match at the top value is not an overflow
	assign advance  = run_ff & count_tick;
	assign match0   = advance && count_ff == cmp0_ff;
	assign match1   = advance && count_ff == cmp1_ff;
	assign overflow = advance && count_ff == tfs_pkg::CNT_MAX && !(match1 && clr_on_match_ff);

	// next count: clear on match 1 when enabled, wrap at the top;
	// a stopped timer holds zero, so every start begins from zero
	always_comb begin
		nxt_count = count_ff;
		if (!run_ff) begin
			nxt_count = 16'h0000;
		end else if (match1 && clr_on_match_ff) begin
			nxt_count = 16'h0000;
		end else if (advance) begin
			nxt_count = count_ff + 16'h0001;
		end
	end

	// up-counter
	// wraps to zero after the top value
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= 16'h0000;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// status set vector
	// every event sets its flag whatever the mask holds
	always_comb begin
		status_set                         = '0;
		status_set[tfs_pkg::ST_OVF_BIT]    = overflow;
		status_set[tfs_pkg::ST_MATCH1_BIT] = match1;
		status_set[tfs_pkg::ST_MATCH0_BIT] = match0;
	end

	// sticky flags: reading clears, a new event in the same cycle wins,
	// so an event that meets the clearing read is never lost
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ff <= '0;
		end else if (rd_status) begin
			status_ff <= status_set;
		end else begin
			status_ff <= status_ff | status_set;
		end
	end

	// per-event requests: a masked event still sets its flag,
	// it only never reaches the interrupt line
	assign irq_req = status_ff & imask_ff;

	// level interrupt, high while any unmasked flag is set
	assign irq = |irq_req;

	// toggle events for the flip-flop
	// capture events arrive already aligned to this clock
	assign trig_ev.capture1 = capture1_event;
	assign trig_ev.capture0 = capture0_event;
	assign trig_ev.match1   = match1;
	assign trig_ev.match0   = match0;

	// timer flip-flop; control writes are expected only while stopped,
	// an invert, set or clear write during counting still acts, ahead of any hardware toggle
	tfs_out_ff u_ff (
		.ref_clk         (ref_clk),
		.arst_n          (arst_n),
		.cmd_valid       (wr_ffcr),
		.cmd             (tfs_pkg::tfs_ff_cmd_e'(reg_wdata[tfs_pkg::FFCR_CMD_LSB +: 2])),
		.trig_en         (trig_en_ff),
		.trig_ev         (trig_ev),
		.timer_flip_flop (timer_out)
	);

	// mode word; capture timing bits stay zero on this channel
	always_comb begin
		mode_word                              = 32'h0000_0000;
		mode_word[tfs_pkg::MODE_CLK_LSB +: 2]  = clk_sel_ff;
		mode_word[tfs_pkg::MODE_CLE_BIT]       = clr_on_match_ff;
		mode_word[tfs_pkg::MODE_SWCAP_BIT]     = 1'b1;
		mode_word[tfs_pkg::MODE_W6_BIT]        = mode_w6_ff;
	end

	// flip-flop control word; the command field never reads back
	always_comb begin
		ffcr_word                              = 32'h0000_0000;
		ffcr_word[7:0]                         = tfs_pkg::FFCR_FIXED_ONES;
		ffcr_word[tfs_pkg::FFCR_C1T_BIT]       = trig_en_ff.capture1_toggle_enable;
		ffcr_word[tfs_pkg::FFCR_C0T_BIT]       = trig_en_ff.capture0_toggle_enable;
		ffcr_word[tfs_pkg::FFCR_E1T_BIT]       = trig_en_ff.match1_toggle_enable;
		ffcr_word[tfs_pkg::FFCR_E0T_BIT]       = trig_en_ff.match0_toggle_enable;
	end

	// status and mask words share one layout
	always_comb begin
		status_word                            = 32'h0000_0000;
		imask_word                             = 32'h0000_0000;
		status_word[tfs_pkg::ST_W-1:0]         = status_ff;
		imask_word[tfs_pkg::ST_W-1:0]          = imask_ff;
	end

	// compare words; the upper half reads zero
	always_comb begin
		cmp0_word                              = 32'h0000_0000;
		cmp1_word                              = 32'h0000_0000;
		cmp0_word[15:0]                        = cmp0_ff;
		cmp1_word[15:0]                        = cmp1_ff;
	end

	// run word
	always_comb begin
		run_word                               = 32'h0000_0000;
		run_word[tfs_pkg::RUN_BIT]             = run_ff;
	end

	// read mux; unmapped offsets return zero
	always_comb begin
		unique case (reg_addr)
			tfs_pkg::OFS_MODE:   nxt_rdata = mode_word;
			tfs_pkg::OFS_FFCR:   nxt_rdata = ffcr_word;
			tfs_pkg::OFS_STATUS: nxt_rdata = status_word;
			tfs_pkg::OFS_IMASK:  nxt_rdata = imask_word;
			tfs_pkg::OFS_CMP0:   nxt_rdata = cmp0_word;
			tfs_pkg::OFS_CMP1:   nxt_rdata = cmp1_word;
			tfs_pkg::OFS_RUN:    nxt_rdata = run_word;
			default:             nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	// and is zero otherwise, so no stale value lingers on the port
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	// registered read data drives the port
	assign reg_rdata = rdata_ff;

endmodule

// ### tb/tfs_timer_properties.sv
// checker: port-level properties of the timer flip-flop and status block
`timescale 1ns/1ps
module tfs_timer_properties (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        arst_n,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// pins and outputs
	input wire logic        serial_clock_pin_input,
	input wire logic        capture0_event,
	input wire logic        capture1_event,
	input wire logic        timer_out,
	input wire logic        irq
);
	logic [1:0] cap_en_ff;
	logic       ffcr_wr;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// software write to the flip-flop control register
	assign ffcr_wr = reg_wr && (reg_addr == tfs_pkg::OFS_FFCR);

	// shadow of the capture toggle enables, so toggles can be predicted
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_en_ff <= 2'h0;
		end else if (ffcr_wr) begin
			cap_en_ff <= reg_wdata[5:4];
		end
	end

	property p_ffcr_read;
		reg_rd && reg_addr == tfs_pkg::OFS_FFCR |=> reg_rdata[1:0] == 2'h3 && reg_rdata[7:6] == 2'h3;
	endproperty
	a_ffcr_read: assert property (p_ffcr_read) else $error("ffcr read field not 11");
	property p_cmp_upper;
		reg_rd && (reg_addr == tfs_pkg::OFS_CMP0 || reg_addr == tfs_pkg::OFS_CMP1)
			|=> reg_rdata[31:16] == 16'h0000;
	endproperty
	a_cmp_upper: assert property (p_cmp_upper) else $error("compare upper bits set");
	property p_mask_upper;
		reg_rd && reg_addr == tfs_pkg::OFS_IMASK |=> reg_rdata[31:3] == 29'h0;
	endproperty
	a_mask_upper: assert property (p_mask_upper) else $error("mask upper bits set");
	property p_mode_rsvd;
		reg_rd && reg_addr == tfs_pkg::OFS_MODE |=> reg_rdata[4:3] == 2'h0 && reg_rdata[5];
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode reserved bits wrong");
	property p_ff_set;
		ffcr_wr && reg_wdata[1:0] == 2'h1 |=> timer_out;
	endproperty
	a_ff_set: assert property (p_ff_set) else $error("flip-flop not set");
	property p_ff_clear;
		ffcr_wr && reg_wdata[1:0] == 2'h2 |=> !timer_out;
	endproperty
	a_ff_clear: assert property (p_ff_clear) else $error("flip-flop not cleared");
	property p_ff_invert;
		ffcr_wr && reg_wdata[1:0] == 2'h0 |=> timer_out != $past(timer_out);
	endproperty
	a_ff_invert: assert property (p_ff_invert) else $error("flip-flop not inverted");
	property p_cap0_toggle;
		capture0_event && cap_en_ff[0] && !ffcr_wr |=> timer_out != $past(timer_out);
	endproperty
	a_cap0_toggle: assert property (p_cap0_toggle) else $error("capture0 toggle missed");
	property p_cap1_toggle;
		capture1_event && cap_en_ff[1] && !ffcr_wr |=> timer_out != $past(timer_out);
	endproperty
	a_cap1_toggle: assert property (p_cap1_toggle) else $error("capture1 toggle missed");
	property p_irq_mask;
		reg_rd && reg_addr == tfs_pkg::OFS_IMASK ##1 reg_rdata[2:0] == 3'h0 |-> !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
endmodule

// ### tb/tfs_timer_test.sv
// self-checking bench for the timer flip-flop and status block
`timescale 1ns/1ps
module tfs_timer_test;
	localparam logic [9:0] CMDS = 10'b11_10_00_00_01;
	logic        ref_clk;
	logic        arst_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        capture0_event;
	logic        capture1_event;
	logic        timer_out;
	logic        irq;
	logic        pin_run;
	logic [2:0]  pin_cnt = 3'h0;
	logic        ff_exp;
	int          bad_count;
	int          total_checks;
	int          n;

	// device under test
	tfs_timer tfs_timer_inst (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_clock_pin_input(pin_cnt[2]), .capture0_event(capture0_event),
		.capture1_event(capture1_event), .timer_out(timer_out), .irq(irq)
	);

	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// serial clock pin with an 8-cycle period while enabled
	always @(posedge ref_clk) begin
		if (pin_run) begin
			pin_cnt <= pin_cnt + 3'h1;
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// read strobe, then compare the data in the following cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(name, exp, reg_rdata);
	endtask

	task automatic chk_ff(input logic e);
		@(posedge ref_clk);
		#1 chk("timer_out", {31'h0, e}, {31'h0, timer_out});
	endtask

	// cycles between two consecutive output changes, bounded
	task automatic period(output int cnt);
		logic v;
		cnt = 0;
		v = timer_out;
		for (int i = 0; i < 3000 && timer_out === v; i++) @(negedge ref_clk);
		v = timer_out;
		while (cnt < 3000 && timer_out === v) begin
			@(negedge ref_clk);
			cnt++;
		end
	endtask

	task automatic pulse(input logic c0, input logic c1);
		@(posedge ref_clk);
		capture0_event <= c0;
		capture1_event <= c1;
		@(posedge ref_clk);
		capture0_event <= 1'b0;
		capture1_event <= 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		repeat (95000) @(posedge ref_clk);
		bad_count++;
		$display("Error watchdog expected end seen hang");
		tally_and_finish();
	end

	// main sequence
	initial begin
		arst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		capture0_event = 1'b0;
		capture1_event = 1'b0;
		pin_run = 1'b0;
		ff_exp = 1'b0;
		bad_count = 0;
		total_checks = 0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(tfs_pkg::OFS_MODE, 32'h20, "mode");
		rd(tfs_pkg::OFS_FFCR, 32'hC3, "ffcr");
		rd(tfs_pkg::OFS_STATUS, 32'h0, "status");
		rd(tfs_pkg::OFS_IMASK, 32'h0, "mask");
		rd(8'h1C, 32'h0, "unmapped");
		chk("irq", 32'h0, {31'h0, irq});
		$display("test reset values done");
		wr(tfs_pkg::OFS_CMP0, 32'hFFFF_1234);
		rd(tfs_pkg::OFS_CMP0, 32'h1234, "cmp0");
		wr(tfs_pkg::OFS_IMASK, 32'hFFFF_FFFF);
		rd(tfs_pkg::OFS_IMASK, 32'h7, "mask");
		wr(tfs_pkg::OFS_IMASK, 32'h0);
		wr(tfs_pkg::OFS_MODE, 32'hFFFF_FFFF);
		rd(tfs_pkg::OFS_MODE, 32'h67, "mode");
		wr(tfs_pkg::OFS_FFCR, 32'h3F);
		rd(tfs_pkg::OFS_FFCR, 32'hFF, "ffcr");
		$display("test register access done");
		for (int k = 0; k < 5; k++) begin
			wr(tfs_pkg::OFS_FFCR, {30'h0, CMDS[2*k +: 2]});
			case (CMDS[2*k +: 2])
				2'h0: ff_exp = !ff_exp;
				2'h1: ff_exp = 1'b1;
				2'h2: ff_exp = 1'b0;
				default: ff_exp = ff_exp;
			endcase
			chk_ff(ff_exp);
		end
		rd(tfs_pkg::OFS_FFCR, 32'hC3, "ffcr");
		$display("test software commands done");
		wr(tfs_pkg::OFS_FFCR, 32'h13);
		pulse(1'b1, 1'b0);
		ff_exp = !ff_exp;
		chk_ff(ff_exp);
		pulse(1'b0, 1'b1);
		chk_ff(ff_exp);
		wr(tfs_pkg::OFS_FFCR, 32'h23);
		pulse(1'b0, 1'b1);
		ff_exp = !ff_exp;
		chk_ff(ff_exp);
		pulse(1'b1, 1'b0);
		chk_ff(ff_exp);
		wr(tfs_pkg::OFS_FFCR, 32'h33);
		pulse(1'b1, 1'b1);
		ff_exp = !ff_exp;
		chk_ff(ff_exp);
		$display("test capture toggles done");
		wr(tfs_pkg::OFS_CMP0, 32'h5);
		wr(tfs_pkg::OFS_CMP1, 32'hA);
		rd(tfs_pkg::OFS_CMP1, 32'hA, "cmp1");
		for (int s = 0; s < 4; s++) begin
			wr(tfs_pkg::OFS_FFCR, s[0] ? 32'h0B : 32'h07);
			wr(tfs_pkg::OFS_MODE, 32'h4 | s);
			wr(tfs_pkg::OFS_RUN, 32'h1);
			pin_run <= 1'b1;
			period(n);
			chk("period", (s == 0) ? 88 : 11 << (2 * s - 2), n);
			wr(tfs_pkg::OFS_RUN, 32'h0);
			pin_run <= 1'b0;
			#1 chk("irq", 32'h0, {31'h0, irq});
			rd(tfs_pkg::OFS_IMASK, 32'h0, "mask");
			wr(tfs_pkg::OFS_IMASK, 32'h1 << s[0]);
			#1 chk("irq", 32'h1, {31'h0, irq});
			rd(tfs_pkg::OFS_STATUS, 32'h3, "status");
			rd(tfs_pkg::OFS_STATUS, 32'h0, "status");
			chk("irq", 32'h0, {31'h0, irq});
			wr(tfs_pkg::OFS_IMASK, 32'h0);
		end
		$display("test clock sources done");
		wr(tfs_pkg::OFS_IMASK, 32'h4);
		wr(tfs_pkg::OFS_MODE, 32'h1);
		wr(tfs_pkg::OFS_RUN, 32'h1);
		repeat (65545) @(posedge ref_clk);
		wr(tfs_pkg::OFS_RUN, 32'h0);
		#1 chk("irq", 32'h1, {31'h0, irq});
		rd(tfs_pkg::OFS_STATUS, 32'h7, "status");
		rd(tfs_pkg::OFS_STATUS, 32'h0, "status");
		chk("irq", 32'h0, {31'h0, irq});
		$display("test overflow done");
		tally_and_finish();
	end
endmodule

// checker attached to the top of the design
bind tfs_timer tfs_timer_properties tfs_timer_properties_inst (
	.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.serial_clock_pin_input(serial_clock_pin_input), .capture0_event(capture0_event),
	.capture1_event(capture1_event), .timer_out(timer_out), .irq(irq)
);
